// file: tcdma_pkg.sv
/*
  Constants for the two-channel DMA controller: register indices, field
  positions, reset values and state encoding.
  Assumes a 32-bit classic Wishbone slave port, byte address
  equal to four times the register index.
*/
package tcdma_pkg;
  localparam int NUM_CH = 2;
  localparam int MEM_AW = 20;
  localparam int REG_AW = 24;
  localparam int CNT_W = 16;
  localparam int IDX_W = 10;
  localparam int WB_AW = 12;

  // Register indices; byte address is index times four
  localparam logic [9:0] IDX_SRC0 = 10'h020;
  localparam logic [9:0] IDX_DST0 = 10'h024;
  localparam logic [9:0] IDX_CNT0 = 10'h028;
  localparam logic [9:0] IDX_CTL0 = 10'h02c;
  localparam logic [9:0] IDX_SRC1 = 10'h030;
  localparam logic [9:0] IDX_DST1 = 10'h034;
  localparam logic [9:0] IDX_CNT1 = 10'h038;
  localparam logic [9:0] IDX_CTL1 = 10'h03c;
  localparam logic [9:0] IDX_RSEL0 = 10'h3b8;
  localparam logic [9:0] IDX_RSEL1 = 10'h3ba;
  localparam logic [9:0] IDX_STAT = 10'h040;
  localparam logic [9:0] IDX_MASK = 10'h041;

  // Channel control fields
  localparam int CTL_EN = 0;
  localparam int CTL_SRC_STEP = 1;
  localparam int CTL_DST_STEP = 2;
  localparam logic [7:0] CTL_WR_MASK = 8'h07;

  // Request select fields
  localparam int RSEL_SRC_LSB = 0;
  localparam int RSEL_SRC_W = 4;
  localparam int RSEL_EXP = 6;
  localparam int RSEL_SW = 7;
  localparam logic [7:0] RSEL_WR_MASK = 8'h4f;

  // Reset values
  localparam logic [23:0] ADDR_RST = 24'h00_0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_UNDERFLOW = 16'hffff;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } tcdma_state_t;
endpackage : tcdma_pkg

// file: tcdma_top.sv
/*
  Two-channel DMA controller with classic Wishbone register slave and a
  simple byte-wide memory master port.
  Assumes all inputs synchronous to core_clk; memory answers with a
  one-cycle mem_ack per request; request lines are level or pulse inputs.
*/
// Our own choice: register access over Wishbone.
// Functional notes
// - There are two independent channels, 0 and 1, each with its own source, destination, count, control and request-select registers.
// - Each channel moves any address to fixed, fixed to any address, or fixed to fixed, inside a 1-Mbyte space.
// - A started channel performs its loaded count plus one transfers.
// - A channel raises its interrupt request when its counter underflows after the final transfer.
// - Bits 0 to 3 of the request-select register choose which request source triggers each transfer.
// - Bit 6 of the request-select register widens the set of sources the four-bit field can reach.
module tcdma_top #(
  parameter int REQ_LINES = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Peripheral request lines
  input wire logic [REQ_LINES-1:0] dma_req_lines,
  // Memory master
  output logic mem_req,
  output logic mem_we,
  output logic [19:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  // Interrupt
  output logic irq
);

  // Register match on word index
  function automatic logic hit(input logic [11:0] adr, input logic [9:0] idx);
    hit = (adr[11:2] == idx);
  endfunction : hit

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    lane_merge = r;
  endfunction : lane_merge

  function automatic logic [9:0] idx_src(input int c);
    idx_src = (c == 0) ? tcdma_pkg::IDX_SRC0 : tcdma_pkg::IDX_SRC1;
  endfunction : idx_src

  function automatic logic [9:0] idx_dst(input int c);
    idx_dst = (c == 0) ? tcdma_pkg::IDX_DST0 : tcdma_pkg::IDX_DST1;
  endfunction : idx_dst

  function automatic logic [9:0] idx_cnt(input int c);
    idx_cnt = (c == 0) ? tcdma_pkg::IDX_CNT0 : tcdma_pkg::IDX_CNT1;
  endfunction : idx_cnt

  function automatic logic [9:0] idx_ctl(input int c);
    idx_ctl = (c == 0) ? tcdma_pkg::IDX_CTL0 : tcdma_pkg::IDX_CTL1;
  endfunction : idx_ctl

  function automatic logic [9:0] idx_rsel(input int c);
    idx_rsel = (c == 0) ? tcdma_pkg::IDX_RSEL0 : tcdma_pkg::IDX_RSEL1;
  endfunction : idx_rsel

  logic [23:0] src_addr [tcdma_pkg::NUM_CH];
  logic [23:0] dst_addr [tcdma_pkg::NUM_CH];
  logic [15:0] xfer_cnt [tcdma_pkg::NUM_CH];
  logic [7:0] ctl [tcdma_pkg::NUM_CH];
  logic [7:0] rsel [tcdma_pkg::NUM_CH];
  logic [tcdma_pkg::NUM_CH-1:0] pend;
  logic [tcdma_pkg::NUM_CH-1:0] status;
  logic [tcdma_pkg::NUM_CH-1:0] mask;
  logic [tcdma_pkg::NUM_CH-1:0] xfer_done;
  logic [tcdma_pkg::NUM_CH-1:0] grant;
  logic [tcdma_pkg::NUM_CH-1:0] underflow;
  tcdma_pkg::tcdma_state_t state;
  logic act_ch;
  logic bus_go;
  logic bus_wr;
  logic [31:0] next_rdata;

  assign bus_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_go & wb_we_i;

  // Per-channel registers and request capture
  for (genvar c = 0; c < tcdma_pkg::NUM_CH; c++)
  begin : g_ch
    logic [4:0] src_sel;
    logic hw_req;
    logic sw_req;
    logic [31:0] wr_src;
    logic [31:0] wr_dst;
    logic [31:0] wr_cnt;
    logic [31:0] wr_ctl;
    logic [31:0] wr_rsel;

    assign wr_src = lane_merge({8'h00, src_addr[c]}, wb_dat_i, wb_sel_i);
    assign wr_dst = lane_merge({8'h00, dst_addr[c]}, wb_dat_i, wb_sel_i);
    assign wr_cnt = lane_merge({16'h0000, xfer_cnt[c]}, wb_dat_i, wb_sel_i);
    assign wr_ctl = lane_merge({24'h00_0000, ctl[c]}, wb_dat_i, wb_sel_i);
    assign wr_rsel = lane_merge({24'h00_0000, rsel[c]}, wb_dat_i, wb_sel_i);
    // Four-bit source field extended by the expansion bit
    assign src_sel = {rsel[c][tcdma_pkg::RSEL_EXP],
                      rsel[c][tcdma_pkg::RSEL_SRC_LSB +: tcdma_pkg::RSEL_SRC_W]};
    assign hw_req = (32'(src_sel) < REQ_LINES) ? dma_req_lines[src_sel] : 1'b0;
    assign sw_req = bus_wr & hit(wb_adr_i, idx_rsel(c)) & wb_sel_i[0]
                    & wb_dat_i[tcdma_pkg::RSEL_SW];
    assign underflow[c] = xfer_done[c] & (xfer_cnt[c] == tcdma_pkg::CNT_RST);

    // Source address: steps only when source is the variable side
    always_ff @(posedge core_clk)
    begin
      if (srst)
      begin
        src_addr[c] <= tcdma_pkg::ADDR_RST;
      end
      else if (bus_wr && hit(wb_adr_i, idx_src(c)))
      begin
        src_addr[c] <= wr_src[23:0];
      end
      else if (xfer_done[c] && ctl[c][tcdma_pkg::CTL_SRC_STEP])
      begin
        src_addr[c] <= src_addr[c] + 24'h00_0001;
      end
    end

    // Destination address: steps only when it is the variable side
    always_ff @(posedge core_clk)
    begin
      if (srst)
      begin
        dst_addr[c] <= tcdma_pkg::ADDR_RST;
      end
      else if (bus_wr && hit(wb_adr_i, idx_dst(c)))
      begin
        dst_addr[c] <= wr_dst[23:0];
      end
      else if (xfer_done[c] && ctl[c][tcdma_pkg::CTL_DST_STEP]
               && !ctl[c][tcdma_pkg::CTL_SRC_STEP])
      begin
        dst_addr[c] <= dst_addr[c] + 24'h00_0001;
      end
    end

    // Transfer counter: loaded value plus one transfers, then underflow
    always_ff @(posedge core_clk)
    begin
      if (srst)
      begin
        xfer_cnt[c] <= tcdma_pkg::CNT_RST;
      end
      else if (bus_wr && hit(wb_adr_i, idx_cnt(c)))
      begin
        xfer_cnt[c] <= wr_cnt[15:0];
      end
      else if (xfer_done[c])
      begin
        xfer_cnt[c] <= xfer_cnt[c] - 16'h0001;
      end
    end

    // Control: enable drops on underflow
    always_ff @(posedge core_clk)
    begin
      if (srst)
      begin
        ctl[c] <= tcdma_pkg::BYTE_RST;
      end
      else if (bus_wr && hit(wb_adr_i, idx_ctl(c)))
      begin
        ctl[c] <= wr_ctl[7:0] & tcdma_pkg::CTL_WR_MASK;
      end
      else if (underflow[c])
      begin
        ctl[c][tcdma_pkg::CTL_EN] <= 1'b0;
      end
    end

    // Request select: bits 4, 5 and 7 are not stored
    always_ff @(posedge core_clk)
    begin
      if (srst)
      begin
        rsel[c] <= tcdma_pkg::BYTE_RST;
      end
      else if (bus_wr && hit(wb_adr_i, idx_rsel(c)))
      begin
        rsel[c] <= wr_rsel[7:0] & tcdma_pkg::RSEL_WR_MASK;
      end
    end

    // Pending request: a new request wins over the grant; the last transfer clears it
    always_ff @(posedge core_clk)
    begin
      if (srst || !ctl[c][tcdma_pkg::CTL_EN] || underflow[c])
      begin
        pend[c] <= 1'b0;
      end
      else if (hw_req || sw_req)
      begin
        pend[c] <= 1'b1;
      end
      else if (grant[c])
      begin
        pend[c] <= 1'b0;
      end
    end
  end : g_ch

  // Fixed priority: channel 0 first
  assign grant[0] = (state == tcdma_pkg::ST_IDLE) & pend[0];
  assign grant[1] = (state == tcdma_pkg::ST_IDLE) & pend[1] & ~pend[0];
  assign xfer_done[0] = (state == tcdma_pkg::ST_WRITE) & mem_ack & ~act_ch;
  assign xfer_done[1] = (state == tcdma_pkg::ST_WRITE) & mem_ack & act_ch;

  // Transfer engine: one byte read from source, then written to destination
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state <= tcdma_pkg::ST_IDLE;
      act_ch <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 20'h0_0000;
      mem_wdata <= tcdma_pkg::BYTE_RST;
    end
    else
    begin
      case (state)
        tcdma_pkg::ST_IDLE:
        begin
          if (|grant)
          begin
            act_ch <= grant[1];
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= src_addr[grant[1]][19:0];
            state <= tcdma_pkg::ST_READ;
          end
        end
        tcdma_pkg::ST_READ:
        begin
          if (mem_ack)
          begin
            mem_we <= 1'b1;
            mem_addr <= dst_addr[act_ch][19:0];
            mem_wdata <= mem_rdata;
            state <= tcdma_pkg::ST_WRITE;
          end
        end
        tcdma_pkg::ST_WRITE:
        begin
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state <= tcdma_pkg::ST_IDLE;
          end
        end
        default:
        begin
          mem_req <= 1'b0;
          mem_we <= 1'b0;
          state <= tcdma_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Interrupt status: set wins over the clearing read
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      status <= '0;
    end
    else
    begin
      for (int c = 0; c < tcdma_pkg::NUM_CH; c++)
      begin
        if (underflow[c])
        begin
          status[c] <= 1'b1;
        end
        else if (bus_go && !wb_we_i && hit(wb_adr_i, tcdma_pkg::IDX_STAT))
        begin
          status[c] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      mask <= '0;
    end
    else if (bus_wr && hit(wb_adr_i, tcdma_pkg::IDX_MASK) && wb_sel_i[0])
    begin
      mask <= wb_dat_i[tcdma_pkg::NUM_CH-1:0];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status & mask);
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb
  begin
    next_rdata = tcdma_pkg::WORD_ZERO;
    for (int c = 0; c < tcdma_pkg::NUM_CH; c++)
    begin
      if (hit(wb_adr_i, idx_src(c)))
      begin
        next_rdata = {8'h00, src_addr[c]};
      end
      if (hit(wb_adr_i, idx_dst(c)))
      begin
        next_rdata = {8'h00, dst_addr[c]};
      end
      if (hit(wb_adr_i, idx_cnt(c)))
      begin
        next_rdata = {16'h0000, xfer_cnt[c]};
      end
      if (hit(wb_adr_i, idx_ctl(c)))
      begin
        next_rdata = {24'h00_0000, ctl[c]};
      end
      if (hit(wb_adr_i, idx_rsel(c)))
      begin
        next_rdata = {24'h00_0000, rsel[c]};
      end
    end
    if (hit(wb_adr_i, tcdma_pkg::IDX_STAT))
    begin
      next_rdata = {30'h0000_0000, status};
    end
    if (hit(wb_adr_i, tcdma_pkg::IDX_MASK))
    begin
      next_rdata = {30'h0000_0000, mask};
    end
  end

  // Wishbone answer: ack one cycle after the strobe, every address acked
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= tcdma_pkg::WORD_ZERO;
    end
    else
    begin
      wb_ack_o <= bus_go;
      if (bus_go && !wb_we_i)
      begin
        wb_dat_o <= next_rdata;
      end
    end
  end

endmodule : tcdma_top

// file: tcdma_top_properties.sv
/*
  Port timing checks for tcdma_top: bus answer, memory phases, interrupt.
  Assumes it is bound into tcdma_top and sees only its ports.
*/
module tcdma_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Memory and interrupt
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [19:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("No ack after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack held too long");
  chk_phase_hold: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_we) && $stable(mem_addr))
    else $error("Memory request changed while waiting");
  chk_read_to_write: assert property (mem_req && !mem_we && mem_ack |=>
    mem_req && mem_we && mem_wdata == $past(mem_rdata))
    else $error("Write phase wrong after read");
  chk_write_end: assert property (mem_req && mem_we && mem_ack |=> !mem_req)
    else $error("No idle cycle after transfer");
  chk_irq_rise: assert property ($rose(irq) |-> $past(mem_ack, 2) || $past(wb_ack_o))
    else $error("Interrupt rose without cause");
  chk_irq_fall: assert property ($fell(irq) |-> $past(wb_ack_o) || $past(srst))
    else $error("Interrupt fell without access");
  chk_reset_quiet: assert property (disable iff (1'b0) srst |=>
    !wb_ack_o && !mem_req && !irq)
    else $error("Outputs active after reset");
endmodule : tcdma_checker

// file: tcdma_top_test.sv
/*
  Bench for tcdma_top: registers, transfers, request selection, interrupt.
  Assumes the bench plays the bus master and a byte memory.
*/
module tcdma_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] dma_req_lines = 32'h0000_0000;
  logic [7:0] mem_rdata = 8'h00;
  logic mem_ack = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, mem_req, mem_we, irq;
  logic [19:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [27:0] wlog[$];
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int lat = 0;
  int wcnt = 0;

  tcdma_top #(
    .REQ_LINES(32)
  ) tcdma_top_inst (
    .core_clk(core_clk),
    .srst(srst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .dma_req_lines(dma_req_lines),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack),
    .irq(irq)
  );

  initial
  begin
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [7:0] pat(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : pat

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Run limit
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  // Byte memory with set latency
  always @(posedge core_clk)
  begin
    if (mem_ack)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_we)
        wlog.push_back({mem_addr, mem_wdata});
    end
    else if (mem_req && wcnt >= lat)
    begin
      mem_ack <= 1'b1;
      wcnt <= 0;
      if (!mem_we)
        mem_rdata <= pat(mem_addr);
    end
    else if (mem_req)
      wcnt <= wcnt + 1;
  end

  task automatic wb(input logic w, input logic [9:0] i, input logic [31:0] d,
                    output logic [31:0] r);
    int n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do
      @(posedge core_clk);
    while (wb_ack_o !== 1'b1 && n++ < 20);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
  endtask : wb

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, i, d, r);
  endtask : wr

  task automatic rd(input logic [9:0] i, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, i, 32'h0000_0000, r);
    chk($sformatf("reg_%h", i), e, r);
  endtask : rd

  // One programmed run of a channel, by line or by software requests
  task automatic run(input int ch, input logic [7:0] ctl, input logic [15:0] cnt,
                     input logic [7:0] sel);
    logic [9:0] b;
    logic [9:0] rs;
    logic [19:0] s;
    logic [19:0] d;
    int n = 0;
    b = ch ? tcdma_pkg::IDX_SRC1 : tcdma_pkg::IDX_SRC0;
    rs = ch ? tcdma_pkg::IDX_RSEL1 : tcdma_pkg::IDX_RSEL0;
    s = 20'h1_2340 + 20'(ch * 16);
    d = 20'h0_0f00 + 20'(ch * 16);
    wlog.delete();
    wr(b, {12'h000, s});
    wr(b + 10'h004, {12'h000, d});
    wr(b + 10'h008, {16'h0000, cnt});
    wr(rs, {24'h00_0000, sel & 8'h7f});
    rd(rs, {24'h00_0000, sel & 8'h4f});
    wr(b + 10'h00c, {24'h00_0000, ctl});
    if (!sel[7])
    begin
      dma_req_lines <= 32'h1 << {~sel[6], sel[3:0]};
      repeat (8) @(posedge core_clk);
      chk("stray", 32'h0, 32'(wlog.size()));
      dma_req_lines <= 32'h1 << {sel[6], sel[3:0]};
    end
    for (int i = 0; i <= int'(cnt); i++)
    begin
      if (sel[7])
        wr(rs, {24'h00_0000, sel});
      while (wlog.size() <= i && n++ < 200)
        @(posedge core_clk);
    end
    dma_req_lines <= 32'h0000_0000;
    repeat (16) @(posedge core_clk);
    chk("count", 32'(cnt) + 32'h1, 32'(wlog.size()));
    foreach (wlog[i])
      chk("write", {4'h0, 20'(d + (ctl[2] && !ctl[1] ? i : 0)),
          pat(20'(s + (ctl[1] ? i : 0)))}, {4'h0, wlog[i]});
    rd(b + 10'h008, 32'h0000_ffff);
    rd(b + 10'h00c, {24'h00_0000, ctl & 8'h06});
    chk("irq", {31'h0, ch == 0}, {31'h0, irq});
    rd(tcdma_pkg::IDX_STAT, 32'h1 << ch);
    rd(tcdma_pkg::IDX_STAT, 32'h0000_0000);
    chk("irq", 32'h0, {31'h0, irq});
  endtask : run

  initial
  begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 32; i < 64; i += 4)
      rd(10'(i), 32'h0000_0000);
    rd(tcdma_pkg::IDX_RSEL0, 32'h0000_0000);
    wr(tcdma_pkg::IDX_SRC0, 32'hffff_ffff);
    rd(tcdma_pkg::IDX_SRC0, 32'h00ff_ffff);
    rd(tcdma_pkg::IDX_SRC1, 32'h0000_0000);
    wr(10'h200, 32'h0000_00ff);
    rd(10'h200, 32'h0000_0000);
    wr(tcdma_pkg::IDX_CTL1, 32'h0000_00f8);
    rd(tcdma_pkg::IDX_CTL1, 32'h0000_0000);
    wr(tcdma_pkg::IDX_RSEL1, 32'h0000_00ff);
    rd(tcdma_pkg::IDX_RSEL1, 32'h0000_004f);
    chk("mem_req", 32'h0, {31'h0, mem_req});
    wr(tcdma_pkg::IDX_MASK, 32'h0000_0001);
    run(0, 8'h03, 16'h0002, 8'h45);
    run(0, 8'h07, 16'h0001, 8'h03);
    lat = 3;
    run(1, 8'h05, 16'h0000, 8'h80);
    run(1, 8'h01, 16'h0001, 8'h80);
    end_of_test();
  end
endmodule : tcdma_top_test

bind tcdma_top tcdma_checker tcdma_checker_inst (
  .core_clk(core_clk),
  .srst(srst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .mem_req(mem_req),
  .mem_we(mem_we),
  .mem_addr(mem_addr),
  .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata),
  .mem_ack(mem_ack),
  .irq(irq)
);
